/* hw/ies_pkg.sv */
// Package for the instruction execute subset: opcodes, flag positions, reset values.
// Assumes one core clock; decode upstream presents one operation per cycle.
package ies_pkg;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IES_OP_NONE = 3'h0,
    IES_OP_POWER_DOWN = 3'h1,
    IES_OP_ROTATE_LEFT = 3'h2,
    IES_OP_ROTATE_RIGHT = 3'h3,
    IES_OP_SUBTRACT = 3'h4,
    IES_OP_NIBBLE_EXCHANGE = 3'h5,
    IES_OP_DIRECTION_LOAD = 3'h6,
    IES_OP_XOR_LITERAL = 3'h7
  } ies_op_t;

  // The 3-bit opcode has all eight slots taken, so the file XOR rides on a separate flag.
  typedef struct packed {
    ies_op_t op;
    logic xor_file;
    logic dest_file;
    logic [4:0] file_addr;
    logic [7:0] literal;
  } ies_instr_t;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
    logic timeout_status_flag;
    logic power_down_flag;
    logic pin_change_wake_flag;
  } ies_flags_t;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [7:0] IES_WATCHDOG_CLEAR = 8'h00;
  localparam logic [7:0] IES_PRESCALER_CLEAR = 8'h00;
  localparam logic [7:0] IES_ACC_RESET = 8'h00;
  localparam logic [7:0] IES_DIR_RESET = 8'hFF;
  localparam logic [4:0] IES_DIR_SEL_A = 5'h06;
  localparam logic [4:0] IES_DIR_SEL_B = 5'h07;
  localparam ies_flags_t IES_FLAGS_RESET = '{carry: 1'b0, digit_carry: 1'b0, zero: 1'b0,
    timeout_status_flag: 1'b1, power_down_flag: 1'b1, pin_change_wake_flag: 1'b0};

endpackage : ies_pkg

/* hw/ies_nibble_adder.sv */
// Four-bit adder slice with carry in and out; two of them make the subtractor.
// Assumes purely combinational use inside the execute stage.
`timescale 1ns/1ps
module ies_nibble_adder (
  // Operands
  input wire logic [3:0] a,
  input wire logic [3:0] b,
  input wire logic cin,
  // Result
  output logic [3:0] sum,
  output logic cout
);
  logic [4:0] full;
  assign full = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  assign sum = full[3:0];
  assign cout = full[4];
endmodule : ies_nibble_adder

/* hw/ies_execute.sv */
// Execute stage for power-down, rotates, subtract, nibble swap, direction load and XOR.
// Assumes decode hands one instruction per cycle with instr_valid, and that the file
// register read data for instr.file_addr is valid combinationally in the same cycle.
//
// Function
// - Power-down clears watchdog counter and its prescaler to zero.
// - Power-down sets timeout flag, clears power-down flag, keeps wake flag.
// - After power-down the core sleeps with instruction oscillator halted.
// - Destination bit zero writes accumulator; one writes back the file register.
// - Rotate right through carry: carry enters bit 7, bit 0 to carry.
// - Subtract computes file minus accumulator, updating carry, digit carry, zero.
// - Nibble exchange swaps low and high nibbles, leaving every flag alone.
// - Direction load copies accumulator to direction register six or seven.
// - File XOR combines accumulator and file bitwise, updating only zero.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module ies_execute (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Instruction from decode
  input wire logic instr_valid,
  input wire ies_pkg::ies_instr_t instr,
  input wire logic [7:0] file_rdata,
  // Wake-up from outside the core clock domain
  input wire logic wake_req,
  // File register write port
  output logic file_we,
  output logic [4:0] file_waddr,
  output logic [7:0] file_wdata,
  // Architectural state
  output logic [7:0] acc,
  output ies_pkg::ies_flags_t flags,
  output logic [7:0] dir_a,
  output logic [7:0] dir_b,
  // Watchdog and sleep
  output logic [7:0] watchdog_counter,
  output logic [7:0] watchdog_prescaler,
  output logic osc_run
);

  // ----------------------------------------------------------------
  // Wake synchroniser
  // ----------------------------------------------------------------
  logic wake_meta_r;
  logic wake_sync_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_meta_r <= 1'b0;
      wake_sync_r <= 1'b0;
    end else begin
      wake_meta_r <= wake_req;
      wake_sync_r <= wake_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [3:0] lo_sum;
  logic [3:0] hi_sum;
  logic lo_carry;
  logic hi_carry;
  logic [7:0] acc_inv;
  assign acc_inv = ~acc;

  // File plus inverted accumulator plus one is the two's complement difference.
  ies_nibble_adder u_lo (
    .a(file_rdata[3:0]),
    .b(acc_inv[3:0]),
    .cin(1'b1),
    .sum(lo_sum),
    .cout(lo_carry)
  );
  ies_nibble_adder u_hi (
    .a(file_rdata[7:4]),
    .b(acc_inv[7:4]),
    .cin(lo_carry),
    .sum(hi_sum),
    .cout(hi_carry)
  );

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    IES_ST_RUN = 1'b0,
    IES_ST_SLEEP = 1'b1
  } ies_state_t;

  ies_state_t state_r, state_nxt;
  logic [7:0] acc_r, acc_nxt;
  ies_pkg::ies_flags_t flags_r, flags_nxt;
  logic [7:0] dir_a_r, dir_a_nxt;
  logic [7:0] dir_b_r, dir_b_nxt;
  logic [7:0] wdog_r, wdog_nxt;
  logic [7:0] pre_r, pre_nxt;
  logic file_we_r, file_we_nxt;
  logic [4:0] file_waddr_r, file_waddr_nxt;
  logic [7:0] file_wdata_r, file_wdata_nxt;

  always_comb begin
    logic [7:0] res;
    logic wr_res;
    res = 8'h00;
    wr_res = 1'b0;
    state_nxt = state_r;
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    dir_a_nxt = dir_a_r;
    dir_b_nxt = dir_b_r;
    wdog_nxt = wdog_r;
    pre_nxt = pre_r;
    file_we_nxt = 1'b0;
    file_waddr_nxt = file_waddr_r;
    file_wdata_nxt = file_wdata_r;
    case (state_r)
      IES_ST_RUN: begin
        if (instr_valid && instr.xor_file) begin
          res = acc_r ^ file_rdata;
          flags_nxt.zero = (res == 8'h00);
          wr_res = 1'b1;
        end else if (instr_valid) begin
          case (instr.op)
            ies_pkg::IES_OP_POWER_DOWN: begin
              wdog_nxt = ies_pkg::IES_WATCHDOG_CLEAR;
              pre_nxt = ies_pkg::IES_PRESCALER_CLEAR;
              flags_nxt.timeout_status_flag = 1'b1;
              flags_nxt.power_down_flag = 1'b0;
              state_nxt = IES_ST_SLEEP;
            end
            ies_pkg::IES_OP_ROTATE_LEFT: begin
              res = {file_rdata[6:0], flags_r.carry};
              flags_nxt.carry = file_rdata[7];
              wr_res = 1'b1;
            end
            ies_pkg::IES_OP_ROTATE_RIGHT: begin
              res = {flags_r.carry, file_rdata[7:1]};
              flags_nxt.carry = file_rdata[0];
              wr_res = 1'b1;
            end
            ies_pkg::IES_OP_SUBTRACT: begin
              res = {hi_sum, lo_sum};
              flags_nxt.carry = hi_carry;
              flags_nxt.digit_carry = lo_carry;
              flags_nxt.zero = ({hi_sum, lo_sum} == 8'h00);
              wr_res = 1'b1;
            end
            ies_pkg::IES_OP_NIBBLE_EXCHANGE: begin
              res = {file_rdata[3:0], file_rdata[7:4]};
              wr_res = 1'b1;
            end
            ies_pkg::IES_OP_DIRECTION_LOAD: begin
              if (instr.file_addr == ies_pkg::IES_DIR_SEL_A) begin
                dir_a_nxt = acc_r;
              end else if (instr.file_addr == ies_pkg::IES_DIR_SEL_B) begin
                dir_b_nxt = acc_r;
              end
            end
            ies_pkg::IES_OP_XOR_LITERAL: begin
              acc_nxt = acc_r ^ instr.literal;
              flags_nxt.zero = ((acc_r ^ instr.literal) == 8'h00);
            end
            default: begin
            end
          endcase
        end
        if (wr_res) begin
          if (instr.dest_file) begin
            file_we_nxt = 1'b1;
            file_waddr_nxt = instr.file_addr;
            file_wdata_nxt = res;
          end else begin
            acc_nxt = res;
          end
        end
      end
      IES_ST_SLEEP: begin
        // Instructions are ignored while asleep; only a synchronised wake leaves.
        if (wake_sync_r) begin
          state_nxt = IES_ST_RUN;
        end
      end
      default: begin
        state_nxt = IES_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= IES_ST_RUN;
      acc_r <= ies_pkg::IES_ACC_RESET;
      flags_r <= ies_pkg::IES_FLAGS_RESET;
      dir_a_r <= ies_pkg::IES_DIR_RESET;
      dir_b_r <= ies_pkg::IES_DIR_RESET;
      wdog_r <= ies_pkg::IES_WATCHDOG_CLEAR;
      pre_r <= ies_pkg::IES_PRESCALER_CLEAR;
      file_we_r <= 1'b0;
      file_waddr_r <= 5'h00;
      file_wdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      dir_a_r <= dir_a_nxt;
      dir_b_r <= dir_b_nxt;
      wdog_r <= wdog_nxt;
      pre_r <= pre_nxt;
      file_we_r <= file_we_nxt;
      file_waddr_r <= file_waddr_nxt;
      file_wdata_r <= file_wdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The watchdog proper lives elsewhere; this stage only forces its clear.
  logic osc_run_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_run_r <= 1'b1;
    end else begin
      osc_run_r <= (state_nxt == IES_ST_RUN);
    end
  end

  assign acc = acc_r;
  assign flags = flags_r;
  assign dir_a = dir_a_r;
  assign dir_b = dir_b_r;
  assign watchdog_counter = wdog_r;
  assign watchdog_prescaler = pre_r;
  assign osc_run = osc_run_r;
  assign file_we = file_we_r;
  assign file_waddr = file_waddr_r;
  assign file_wdata = file_wdata_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic run_go;
  assign run_go = instr_valid && (state_r == IES_ST_RUN);

  a_sleep_clears_wdog: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && !instr.xor_file && instr.op == ies_pkg::IES_OP_POWER_DOWN
    |=> wdog_r == 8'h00 && pre_r == 8'h00) else $error("watchdog not cleared");
  a_sleep_flags: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && !instr.xor_file && instr.op == ies_pkg::IES_OP_POWER_DOWN
    |=> flags_r.timeout_status_flag && !flags_r.power_down_flag
    && flags_r.pin_change_wake_flag == $past(flags_r.pin_change_wake_flag))
    else $error("power-down flags wrong");
  a_sleep_osc_stop: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && !instr.xor_file && instr.op == ies_pkg::IES_OP_POWER_DOWN
    |=> !osc_run && state_r == IES_ST_SLEEP) else $error("oscillator still running");
  a_dest_file_write: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && instr.xor_file && instr.dest_file
    |=> file_we && acc == $past(acc)) else $error("file destination missed");
  a_rotate_right: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && !instr.xor_file && instr.op == ies_pkg::IES_OP_ROTATE_RIGHT && !instr.dest_file
    |=> acc == {$past(flags_r.carry), $past(file_rdata[7:1])}
    && flags_r.carry == $past(file_rdata[0])) else $error("rotate right wrong");
  a_subtract: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && !instr.xor_file && instr.op == ies_pkg::IES_OP_SUBTRACT && !instr.dest_file
    |=> acc == 8'($past(file_rdata) - $past(acc))
    && flags_r.carry == ($past(file_rdata) >= $past(acc))) else $error("subtract wrong");
  a_swap_flags: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && !instr.xor_file && instr.op == ies_pkg::IES_OP_NIBBLE_EXCHANGE
    |=> flags_r == $past(flags_r)) else $error("swap touched flags");
  a_dir_load: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && !instr.xor_file && instr.op == ies_pkg::IES_OP_DIRECTION_LOAD
    && instr.file_addr == ies_pkg::IES_DIR_SEL_B
    |=> dir_b == $past(acc) && flags_r == $past(flags_r)) else $error("direction load wrong");
  a_xor_file: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && instr.xor_file && !instr.dest_file
    |=> acc == ($past(acc) ^ $past(file_rdata)) && flags_r.carry == $past(flags_r.carry))
    else $error("file xor wrong");
  a_rotate_left: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && !instr.xor_file && instr.op == ies_pkg::IES_OP_ROTATE_LEFT && instr.dest_file
    |=> file_wdata == {$past(file_rdata[6:0]), $past(flags_r.carry)}
    && flags_r.carry == $past(file_rdata[7])) else $error("rotate left wrong");
  a_xor_literal: assert property (@(posedge ref_clk) disable iff (rst)
    run_go && !instr.xor_file && instr.op == ies_pkg::IES_OP_XOR_LITERAL
    |=> acc == ($past(acc) ^ $past(instr.literal)) && !file_we) else $error("literal xor wrong");

  c_sleep_wake: cover property (@(posedge ref_clk) disable iff (rst)
    state_r == IES_ST_SLEEP ##1 state_r == IES_ST_RUN);
  c_sub_zero: cover property (@(posedge ref_clk) disable iff (rst)
    run_go && !instr.xor_file && instr.op == ies_pkg::IES_OP_SUBTRACT ##1 flags_r.zero);
  c_file_write: cover property (@(posedge ref_clk) disable iff (rst) file_we);

endmodule : ies_execute

/* tb/ies_execute_tb_top.sv */
// Self-checking bench for the execute stage: random and directed instructions.
// Assumes the bench plays decode and the file register array, with write forwarding.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module ies_execute_tb_top;
  // ----------------------------------------------------------------
  // Signals and expected state
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  ies_pkg::ies_instr_t instr = '0;
  logic [7:0] file_rdata;
  logic wake_req = 1'b0;
  logic file_we;
  logic [4:0] file_waddr;
  logic [7:0] file_wdata;
  logic [7:0] acc, dir_a, dir_b, watchdog_counter, watchdog_prescaler;
  ies_pkg::ies_flags_t flags;
  logic osc_run;
  logic [7:0] mem [32];
  logic [7:0] e_acc = ies_pkg::IES_ACC_RESET;
  logic [7:0] e_dir_a = ies_pkg::IES_DIR_RESET;
  logic [7:0] e_dir_b = ies_pkg::IES_DIR_RESET;
  ies_pkg::ies_flags_t e_flags = ies_pkg::IES_FLAGS_RESET;
  logic e_run = 1'b1;
  logic e_we = 1'b0;
  logic [4:0] e_waddr = '0;
  logic [7:0] e_wdata = '0;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #4 ref_clk = ~ref_clk;
  // A write lands in the array one edge late, so the pending write is forwarded.
  assign file_rdata = (file_we && file_waddr == instr.file_addr) ? file_wdata
                                                                 : mem[instr.file_addr];
  always @(posedge ref_clk) begin
    if (file_we) mem[file_waddr] <= file_wdata;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  ies_execute uut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .wake_req(wake_req), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .acc(acc), .flags(flags),
    .dir_a(dir_a), .dir_b(dir_b), .watchdog_counter(watchdog_counter),
    .watchdog_prescaler(watchdog_prescaler), .osc_run(osc_run));
  // ----------------------------------------------------------------
  // Model and drivers
  // ----------------------------------------------------------------
  function automatic ies_pkg::ies_instr_t mk(ies_pkg::ies_op_t op, logic xf, logic d,
                                             logic [4:0] a, logic [7:0] lit);
    ies_pkg::ies_instr_t i;
    i.op = op;
    i.xor_file = xf;
    i.dest_file = d;
    i.file_addr = a;
    i.literal = lit;
    return i;
  endfunction : mk
  task automatic apply(ies_pkg::ies_instr_t i, logic [7:0] f);
    logic [7:0] r;
    logic wr;
    r = '0;
    wr = 1'b0;
    if (i.xor_file) begin
      r = e_acc ^ f;
      e_flags.zero = (r == 8'h00);
      wr = 1'b1;
    end else begin
      case (i.op)
        ies_pkg::IES_OP_POWER_DOWN: begin
          e_flags.timeout_status_flag = 1'b1;
          e_flags.power_down_flag = 1'b0;
          e_run = 1'b0;
        end
        ies_pkg::IES_OP_ROTATE_LEFT: begin
          r = {f[6:0], e_flags.carry};
          e_flags.carry = f[7];
          wr = 1'b1;
        end
        ies_pkg::IES_OP_ROTATE_RIGHT: begin
          r = {e_flags.carry, f[7:1]};
          e_flags.carry = f[0];
          wr = 1'b1;
        end
        ies_pkg::IES_OP_SUBTRACT: begin
          r = f - e_acc;
          e_flags.carry = (f >= e_acc);
          e_flags.digit_carry = (f[3:0] >= e_acc[3:0]);
          e_flags.zero = (r == 8'h00);
          wr = 1'b1;
        end
        ies_pkg::IES_OP_NIBBLE_EXCHANGE: begin
          r = {f[3:0], f[7:4]};
          wr = 1'b1;
        end
        ies_pkg::IES_OP_DIRECTION_LOAD: begin
          if (i.file_addr == ies_pkg::IES_DIR_SEL_A) e_dir_a = e_acc;
          if (i.file_addr == ies_pkg::IES_DIR_SEL_B) e_dir_b = e_acc;
        end
        ies_pkg::IES_OP_XOR_LITERAL: begin
          e_acc = e_acc ^ i.literal;
          e_flags.zero = (e_acc == 8'h00);
        end
        default: ;
      endcase
    end
    if (wr && i.dest_file) begin
      e_we = 1'b1;
      e_waddr = i.file_addr;
      e_wdata = r;
    end else if (wr) begin
      e_acc = r;
    end
  endtask : apply
  task automatic check();
    `CHK(acc, e_acc)
    `CHK(flags, e_flags)
    `CHK({dir_a, dir_b}, {e_dir_a, e_dir_b})
    `CHK({watchdog_counter, watchdog_prescaler}, 16'h0000)
    `CHK(osc_run, e_run)
    `CHK(file_we, e_we)
    if (e_we) `CHK({file_waddr, file_wdata}, {e_waddr, e_wdata})
  endtask : check
  task automatic step(ies_pkg::ies_instr_t i, logic v);
    @(posedge ref_clk);
    instr_valid <= v;
    instr <= i;
    #1;
    check();
    e_we = 1'b0;
    if (v && e_run) apply(i, file_rdata);
  endtask : step
  task automatic run_random(int n);
    ies_pkg::ies_op_t o;
    for (int k = 0; k < n; k++) begin
      o = ies_pkg::ies_op_t'($urandom_range(7, 0));
      if (o == ies_pkg::IES_OP_POWER_DOWN) o = ies_pkg::IES_OP_NONE;
      step(mk(o, $urandom_range(7, 0) == 0, $urandom_range(1, 0), 5'($urandom_range(31, 0)),
        8'($urandom)), $urandom_range(7, 0) != 0);
    end
  endtask : run_random
  task automatic sleep_wake();
    int n;
    step(mk(ies_pkg::IES_OP_POWER_DOWN, 1'b0, 1'b0, 5'h00, 8'h00), 1'b1);
    run_random(6);
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    wake_req <= 1'b1;
    n = 0;
    while (osc_run !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(osc_run, 1'b1)
    e_run = 1'b1;
    wake_req <= 1'b0;
    step(mk(ies_pkg::IES_OP_NONE, 1'b0, 1'b0, 5'h00, 8'h00), 1'b0);
  endtask : sleep_wake
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(26));
    for (int k = 0; k < 32; k++) mem[k] = 8'($urandom);
    repeat (5) @(posedge ref_clk);
    #1;
    check();
    rst <= 1'b0;
    step(mk(ies_pkg::IES_OP_XOR_LITERAL, 1'b0, 1'b0, 5'h00, 8'hA5), 1'b1);
    for (int a = 5; a < 9; a++) begin
      step(mk(ies_pkg::IES_OP_DIRECTION_LOAD, 1'b0, 1'b0, 5'(a), 8'h00), 1'b1);
    end
    step(mk(ies_pkg::IES_OP_NONE, 1'b0, 1'b0, 5'h00, 8'h00), 1'b0);
    step(mk(ies_pkg::IES_OP_NONE, 1'b0, 1'b0, 5'h00, 8'h00), 1'b0);
    // Make the accumulator equal to file 3 so the subtract hits the zero corner.
    step(mk(ies_pkg::IES_OP_XOR_LITERAL, 1'b0, 1'b0, 5'h00, e_acc ^ mem[3]), 1'b1);
    step(mk(ies_pkg::IES_OP_SUBTRACT, 1'b0, 1'b1, 5'h03, 8'h00), 1'b1);
    step(mk(ies_pkg::IES_OP_XOR_LITERAL, 1'b0, 1'b0, 5'h00, e_acc), 1'b1);
    run_random(1500);
    sleep_wake();
    run_random(1500);
    step(mk(ies_pkg::IES_OP_NONE, 1'b0, 1'b0, 5'h00, 8'h00), 1'b0);
    stop_test();
  end
endmodule : ies_execute_tb_top
